// ==== rbc_top.sv ====
/*
 * Reset sequencing, forced reset states and RAM back-up control for a
 * small 4-bit controller, with an Avalon-MM register slave.
 * Assumes the core presents one decoded instruction per valid strobe and
 * that detector and pin inputs are synchronous to sys_clk.
 */
// Our own choices: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps

module rbc_top (
	input  wire logic                    sys_clk,
	input  wire logic                    sys_rst,
	input  wire logic [rbc_pkg::AW-1:0]  avs_address,
	input  wire logic                    avs_read,
	input  wire logic                    avs_write,
	input  wire logic [rbc_pkg::DW-1:0]  avs_writedata,
	output logic      [rbc_pkg::DW-1:0]  avs_readdata,
	output logic                         avs_waitrequest,
	input  wire logic                    ext_rst_n,
	input  wire logic                    por_det,
	input  wire logic                    vdrop_det,
	input  wire logic                    wdt_expire,
	input  wire logic [1:0]              wake_req,
	input  wire rbc_pkg::rbc_instr_s     instr,
	output logic                         core_reset,
	output logic                         fetch_zero,
	output logic                         skip_next,
	output logic                         warm_flag,
	output logic                         osc_stop,
	output logic                         periph_halt,
	output logic                         vdrop_enable,
	output logic                         io_force_hiz,
	output logic                         io_latch_one,
	output logic                         pullup_force_off,
	output logic      [3:0]              pullup_en_b,
	output logic      [3:0]              pullup_en_c,
	output rbc_pkg::rbc_regs_s           regs
);

	// ****************************************************************
	// Reset sources
	// ****************************************************************
	logic [1:0]          ext_cnt_q;
	logic                ext_long;
	logic                cold;
	logic                wake_go;
	logic                core_reset_q;
	logic                fetch_zero_q;
	rbc_pkg::rbc_state_e state_q;
	logic                armed_q;
	logic                warm_q;
	logic                skip_q;
	rbc_pkg::rbc_regs_s  regs_q;

	function automatic logic is_pd(input rbc_pkg::rbc_op_e op);
		is_pd = (op == rbc_pkg::OP_PD_KEEP) || (op == rbc_pkg::OP_PD_FULL);
	endfunction

	// Counts consecutive low samples of the external reset pin
	always_ff @(posedge sys_clk) begin
		if (sys_rst || ext_rst_n) begin
			ext_cnt_q <= 2'h0;
		end else if (ext_cnt_q != rbc_pkg::MACH_CYC_CLKS) begin
			ext_cnt_q <= ext_cnt_q + 2'h1;
		end
	end

	assign ext_long = (ext_cnt_q == rbc_pkg::MACH_CYC_CLKS);
	// Detector only counts while it is powered; full back-up switches it off
	assign vdrop_enable = (state_q != rbc_pkg::ST_BK_FULL);
	assign cold = sys_rst | por_det | ext_long | wdt_expire | (vdrop_det & vdrop_enable);
	// of the wakeup pins only a qualified one leaves back-up; a cold reset also leaves it
	assign wake_go = (state_q != rbc_pkg::ST_RUN) & ~cold &
		|(wake_req & {|regs_q.wakeup_ctrl_b, |regs_q.wakeup_ctrl_a});

	// ****************************************************************
	// Core reset and restart
	// ****************************************************************
	// restart at zero after release
	always_ff @(posedge sys_clk) begin
		core_reset_q <= cold | wake_go;
		fetch_zero_q <= core_reset_q & ~(cold | wake_go);
	end

	assign core_reset = core_reset_q;
	assign fetch_zero = fetch_zero_q;

	// ports float with latches at one
	assign io_force_hiz     = core_reset_q;
	assign io_latch_one     = core_reset_q;
	assign pullup_force_off = core_reset_q;
	assign pullup_en_b      = regs_q.pullup_ctrl_b & ~{4{core_reset_q}};
	assign pullup_en_c      = regs_q.pullup_ctrl_c & ~{4{core_reset_q}};

	// ****************************************************************
	// Power-down sequencing
	// ****************************************************************
	// Arming lasts exactly one instruction; any other instruction disarms
	always_ff @(posedge sys_clk) begin
		if (cold) begin
			armed_q <= 1'b0;
		end else if (instr.valid) begin
			armed_q <= (instr.op == rbc_pkg::OP_ARM);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (cold || wake_go) begin
			state_q <= rbc_pkg::ST_RUN;
		end else if (state_q == rbc_pkg::ST_RUN && instr.valid && armed_q) begin
			unique case (instr.op)
				rbc_pkg::OP_PD_KEEP: begin
					state_q <= rbc_pkg::ST_BK_KEEP;
				end
				rbc_pkg::OP_PD_FULL: begin
					state_q <= rbc_pkg::ST_BK_FULL;
				end
				default: begin
					state_q <= rbc_pkg::ST_RUN;
				end
			endcase
		end
	end

	assign osc_stop    = (state_q != rbc_pkg::ST_RUN);
	assign periph_halt = (state_q == rbc_pkg::ST_BK_FULL);

	// cold reset clears it, cold wins over a same-cycle wakeup
	always_ff @(posedge sys_clk) begin
		if (cold) begin
			warm_q <= 1'b0;
		end else if (wake_go) begin
			warm_q <= 1'b1;
		end
	end

	assign warm_flag = warm_q;

	// skip pulse for the flag test instruction
	always_ff @(posedge sys_clk) begin
		skip_q <= ~cold & instr.valid & (instr.op == rbc_pkg::OP_SKIP_WARM) & warm_q;
	end

	assign skip_next = skip_q;

	// ****************************************************************
	// Register file
	// ****************************************************************
	logic       bus_req;
	logic       ack_q;
	logic       wr_go;
	logic [3:0] wnib;
	logic [31:0] rd_d;
	logic [31:0] rd_q;

	// One wait state: request seen, answer at the following edge
	assign bus_req         = avs_read | avs_write;
	assign avs_waitrequest = bus_req & ~ack_q;
	assign wr_go           = avs_write & ack_q;
	assign wnib            = avs_writedata[3:0];

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= bus_req & ~ack_q;
		end
	end

	// timer, wakeup and pull-up controls cleared
	// converter mode and done flag cleared
	// same values on every cold reset
	// Flags live here too: the whole struct must have a single driver
	always_ff @(posedge sys_clk) begin
		if (cold) begin
			regs_q.irq_ctrl_a       <= rbc_pkg::NIB_RST;
			regs_q.irq_ctrl_b       <= rbc_pkg::NIB_RST;
			regs_q.ext_irq_ctrl     <= rbc_pkg::NIB_RST;
			regs_q.timer_ctrl_c     <= rbc_pkg::NIB_RST;
			regs_q.wakeup_ctrl_a    <= rbc_pkg::NIB_RST;
			regs_q.wakeup_ctrl_b    <= rbc_pkg::NIB_RST;
			regs_q.pullup_ctrl_b    <= rbc_pkg::NIB_RST;
			regs_q.pullup_ctrl_c    <= rbc_pkg::NIB_RST;
			regs_q.conv_mode_select <= rbc_pkg::NIB_RST;
			regs_q.flags            <= rbc_pkg::FLAGS_RST;
		end else if (wake_go) begin
			// Interrupt controls A and B and flags do not survive back-up; ext_irq_ctrl does
			regs_q.irq_ctrl_a <= rbc_pkg::NIB_RST;
			regs_q.irq_ctrl_b <= rbc_pkg::NIB_RST;
			regs_q.flags      <= rbc_pkg::FLAGS_RST;
		end else if (wr_go) begin
			unique case (avs_address)
				rbc_pkg::OFS_IRQ_CTRL_A:   regs_q.irq_ctrl_a       <= wnib;
				rbc_pkg::OFS_IRQ_CTRL_B:   regs_q.irq_ctrl_b       <= wnib;
				rbc_pkg::OFS_EXT_IRQ_CTRL: regs_q.ext_irq_ctrl     <= wnib;
				rbc_pkg::OFS_TIMER_CTRL_C: regs_q.timer_ctrl_c     <= wnib;
				rbc_pkg::OFS_WAKEUP_A:     regs_q.wakeup_ctrl_a    <= wnib;
				rbc_pkg::OFS_WAKEUP_B:     regs_q.wakeup_ctrl_b    <= wnib;
				rbc_pkg::OFS_PULLUP_B:     regs_q.pullup_ctrl_b    <= wnib;
				rbc_pkg::OFS_PULLUP_C:     regs_q.pullup_ctrl_c    <= wnib;
				rbc_pkg::OFS_CONV_MODE:    regs_q.conv_mode_select <= wnib;
				rbc_pkg::OFS_FLAGS:        regs_q.flags            <= avs_writedata[6:0];
				default: begin
				end
			endcase
		end
	end

	assign regs = regs_q;

	// Read mux; unmapped offsets read zero and writes there are dropped
	always_comb begin
		rd_d = 32'h0000_0000;
		unique case (avs_address)
			rbc_pkg::OFS_IRQ_CTRL_A:   rd_d[3:0] = regs_q.irq_ctrl_a;
			rbc_pkg::OFS_IRQ_CTRL_B:   rd_d[3:0] = regs_q.irq_ctrl_b;
			rbc_pkg::OFS_EXT_IRQ_CTRL: rd_d[3:0] = regs_q.ext_irq_ctrl;
			rbc_pkg::OFS_TIMER_CTRL_C: rd_d[3:0] = regs_q.timer_ctrl_c;
			rbc_pkg::OFS_WAKEUP_A:     rd_d[3:0] = regs_q.wakeup_ctrl_a;
			rbc_pkg::OFS_WAKEUP_B:     rd_d[3:0] = regs_q.wakeup_ctrl_b;
			rbc_pkg::OFS_PULLUP_B:     rd_d[3:0] = regs_q.pullup_ctrl_b;
			rbc_pkg::OFS_PULLUP_C:     rd_d[3:0] = regs_q.pullup_ctrl_c;
			rbc_pkg::OFS_CONV_MODE:    rd_d[3:0] = regs_q.conv_mode_select;
			rbc_pkg::OFS_FLAGS:        rd_d[6:0] = regs_q.flags;
			rbc_pkg::OFS_STATUS:       rd_d[4:0] = {core_reset_q, armed_q, state_q, warm_q};
			default: begin
			end
		endcase
	end

	// Data is latched on the wait edge so it stands at the release edge
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			rd_q <= 32'h0000_0000;
		end else if (avs_read && !ack_q) begin
			rd_q <= rd_d;
		end
	end

	assign avs_readdata = rd_q;

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);

	sequence arm_s;
		instr.valid && instr.op == rbc_pkg::OP_ARM;
	endsequence

	sequence pd_s;
		instr.valid && is_pd(instr.op) && !cold;
	endsequence

	ext_reset_hold_a: assert property (
		!ext_rst_n [*4] |=> core_reset)
		else $error("external reset held low did not reset");

	restart_zero_a: assert property (
		$fell(core_reset) |-> $past(fetch_zero_q) == 1'b0 ##0 fetch_zero)
		else $error("no restart at zero after reset release");

	power_on_a: assert property (
		por_det |=> core_reset ##0 regs.flags == rbc_pkg::FLAGS_RST)
		else $error("power-on detect did not reset");

	port_hiz_a: assert property (
		core_reset |-> io_force_hiz && io_latch_one && pullup_force_off
		&& pullup_en_b == rbc_pkg::NIB_RST && pullup_en_c == rbc_pkg::NIB_RST)
		else $error("ports not forced during reset");

	reg_clear_a: assert property (
		cold |=> regs.irq_ctrl_a == rbc_pkg::NIB_RST && regs.ext_irq_ctrl == rbc_pkg::NIB_RST
		&& regs.wakeup_ctrl_b == rbc_pkg::NIB_RST && regs.conv_mode_select == rbc_pkg::NIB_RST)
		else $error("control registers not cleared by reset");

	wdog_armed_a: assert property (
		cold |=> regs.flags[rbc_pkg::FLG_WEF] && !regs.flags[rbc_pkg::FLG_GIE])
		else $error("watchdog enable not set by reset");

	vdrop_reset_a: assert property (
		vdrop_det && state_q != rbc_pkg::ST_BK_FULL |=> core_reset && !warm_flag)
		else $error("voltage drop did not reset");

	backup_entry_a: assert property (
		arm_s ##1 (pd_s and (state_q == rbc_pkg::ST_RUN)) |=> osc_stop)
		else $error("armed power-down did not enter back-up");

	pd_nop_a: assert property (
		pd_s and (!armed_q && state_q == rbc_pkg::ST_RUN) |=> !osc_stop)
		else $error("unarmed power-down was not ignored");

	full_halt_a: assert property (
		state_q == rbc_pkg::ST_BK_FULL |-> periph_halt && !vdrop_enable)
		else $error("full back-up left peripherals running");

	warm_flag_a: assert property (
		wake_go |=> warm_flag && core_reset ##1 fetch_zero || core_reset)
		else $error("wakeup did not restart warm");

	wake_only_a: assert property (
		osc_stop && !wake_go && !cold |=> osc_stop)
		else $error("back-up left without wakeup");

endmodule

// ==== rbc_pkg.sv ====
/*
 * Shared constants, types and register map for the reset and RAM back-up
 * controller. Assumes one 100 MHz system clock and an Avalon-MM master.
 */
package rbc_pkg;

	// ****************************************************************
	// Bus and register map
	// ****************************************************************
	localparam int unsigned AW = 6;
	localparam int unsigned DW = 32;
	localparam logic [5:0] OFS_IRQ_CTRL_A   = 6'h00;
	localparam logic [5:0] OFS_IRQ_CTRL_B   = 6'h04;
	localparam logic [5:0] OFS_EXT_IRQ_CTRL = 6'h08;
	localparam logic [5:0] OFS_TIMER_CTRL_C = 6'h0C;
	localparam logic [5:0] OFS_WAKEUP_A     = 6'h10;
	localparam logic [5:0] OFS_WAKEUP_B     = 6'h14;
	localparam logic [5:0] OFS_PULLUP_B     = 6'h18;
	localparam logic [5:0] OFS_PULLUP_C     = 6'h1C;
	localparam logic [5:0] OFS_CONV_MODE    = 6'h20;
	localparam logic [5:0] OFS_FLAGS        = 6'h24;
	localparam logic [5:0] OFS_STATUS       = 6'h28;

	// ****************************************************************
	// Field layout and reset values
	// ****************************************************************
	localparam logic [3:0] NIB_RST = 4'h0;
	localparam int unsigned FLG_GIE   = 0;
	localparam int unsigned FLG_TMR_A = 1;
	localparam int unsigned FLG_TMR_B = 2;
	localparam int unsigned FLG_WDF_A = 3;
	localparam int unsigned FLG_WDF_B = 4;
	localparam int unsigned FLG_WEF   = 5;
	localparam int unsigned FLG_CONV  = 6;
	localparam logic [6:0] FLAGS_RST  = 7'h20;
	localparam logic [3:0] ALL_ONES4  = 4'hF;

	// ****************************************************************
	// Timing: one machine cycle in system clocks
	// ****************************************************************
	localparam logic [1:0] MACH_CYC_CLKS = 2'h3;

	// ****************************************************************
	// Types
	// ****************************************************************
	typedef enum logic [2:0] {
		OP_OTHER     = 3'b000,
		OP_ARM       = 3'b001,
		OP_PD_KEEP   = 3'b010,
		OP_PD_FULL   = 3'b011,
		OP_SKIP_WARM = 3'b100
	} rbc_op_e;

	typedef enum logic [1:0] {
		ST_RUN     = 2'b00,
		ST_BK_KEEP = 2'b01,
		ST_BK_FULL = 2'b10
	} rbc_state_e;

	typedef struct packed {
		logic    valid;
		rbc_op_e op;
	} rbc_instr_s;

	typedef struct packed {
		logic [3:0] irq_ctrl_a;
		logic [3:0] irq_ctrl_b;
		logic [3:0] ext_irq_ctrl;
		logic [3:0] timer_ctrl_c;
		logic [3:0] wakeup_ctrl_a;
		logic [3:0] wakeup_ctrl_b;
		logic [3:0] pullup_ctrl_b;
		logic [3:0] pullup_ctrl_c;
		logic [3:0] conv_mode_select;
		logic [6:0] flags;
	} rbc_regs_s;

endpackage

// ==== rbc_core_model.sv ====
/*
 * Behavioural model of the processor core beside the reset and RAM
 * back-up controller: issues decoded instructions and notes skips.
 * Assumes the bench requests one instruction at a time on cmd_go.
 */
`timescale 1ns/1ps

module rbc_core_model (
	input  wire logic             sys_clk,
	input  wire logic             cmd_go,
	input  wire rbc_pkg::rbc_op_e cmd_op,
	input  wire logic             core_reset,
	input  wire logic             skip_next,
	output rbc_pkg::rbc_instr_s   instr,
	output logic                  skip_seen
);
	// ****************************************************************
	// Instruction issue
	// ****************************************************************
	// one op per request, none while the core is held in reset
	// Idle cycles invert the op field, so a stale op returns every other cycle; only the low valid bit keeps it from acting
	always_ff @(posedge sys_clk) begin
		instr.valid <= cmd_go & ~core_reset;
		instr.op    <= cmd_go ? cmd_op : rbc_pkg::rbc_op_e'(~instr.op);
	end

	// a taken skip is remembered until the next request
	always_ff @(posedge sys_clk) begin
		if (cmd_go)
			skip_seen <= 1'b0;
		else if (skip_next)
			skip_seen <= 1'b1;
	end
endmodule

// ==== tb_rbc_top.sv ====
/*
 * Self-checking bench for the reset and RAM back-up controller.
 * Assumes the core model file and the design package are compiled first.
 */
`timescale 1ns/1ps

module tb_rbc_top;
	logic                      sys_clk = 1'b0;
	logic                      sys_rst;
	logic [rbc_pkg::AW-1:0]    avs_address;
	logic                      avs_read;
	logic                      avs_write;
	logic [rbc_pkg::DW-1:0]    avs_writedata;
	logic [rbc_pkg::DW-1:0]    avs_readdata;
	logic                      avs_waitrequest;
	logic                      ext_rst_n;
	logic                      por_det;
	logic                      vdrop_det;
	logic                      wdt_expire;
	logic [1:0]                wake_req;
	rbc_pkg::rbc_instr_s       instr;
	logic                      core_reset;
	logic                      fetch_zero;
	logic                      skip_next;
	logic                      warm_flag;
	logic                      osc_stop;
	logic                      periph_halt;
	logic                      vdrop_enable;
	logic                      io_force_hiz;
	logic                      io_latch_one;
	logic                      pullup_force_off;
	logic [3:0]                pullup_en_b;
	logic [3:0]                pullup_en_c;
	rbc_pkg::rbc_regs_s        regs;
	logic                      cmd_go;
	rbc_pkg::rbc_op_e          cmd_op;
	logic                      skip_seen;
	logic [31:0]               rd;
	int                        err_total;
	int                        n_checks;
	// Every control nibble zero, only the watchdog enable flag set
	localparam rbc_pkg::rbc_regs_s RST_REGS = '{flags: rbc_pkg::FLAGS_RST, default: '0};

	rbc_top i_rbc_top (.sys_clk(sys_clk), .sys_rst(sys_rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.ext_rst_n(ext_rst_n), .por_det(por_det), .vdrop_det(vdrop_det),
		.wdt_expire(wdt_expire), .wake_req(wake_req), .instr(instr),
		.core_reset(core_reset), .fetch_zero(fetch_zero), .skip_next(skip_next),
		.warm_flag(warm_flag), .osc_stop(osc_stop), .periph_halt(periph_halt),
		.vdrop_enable(vdrop_enable), .io_force_hiz(io_force_hiz),
		.io_latch_one(io_latch_one), .pullup_force_off(pullup_force_off),
		.pullup_en_b(pullup_en_b), .pullup_en_c(pullup_en_c), .regs(regs));

	rbc_core_model i_rbc_core_model (.sys_clk(sys_clk), .cmd_go(cmd_go), .cmd_op(cmd_op),
		.core_reset(core_reset), .skip_next(skip_next), .instr(instr),
		.skip_seen(skip_seen));

	// 100 MHz clock
	always #5 sys_clk = ~sys_clk;

	// ****************************************************************
	// Shared tasks
	// ****************************************************************
	task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %0h seen %0h", what, exp, got);
		end
	endtask

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// Avalon cycle: hold everything until waitrequest is seen low
	task automatic bus(input logic wr, input logic [5:0] adr, input logic [31:0] wd);
		int n;
		@(posedge sys_clk);
		avs_address   <= adr;
		avs_writedata <= wd;
		avs_write     <= wr;
		avs_read      <= ~wr;
		n = 0;
		do begin
			@(negedge sys_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		if (n >= 50)
			chk("bus answer", 0, 1);
		rd = avs_readdata;
		@(posedge sys_clk);
		avs_write <= 1'b0;
		avs_read  <= 1'b0;
	endtask

	task automatic rd_chk(input string what, input logic [5:0] adr, input logic [31:0] exp);
		bus(1'b0, adr, 32'h0);
		chk(what, exp, rd);
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	task automatic wait_rst(input logic v);
		int n;
		n = 0;
		do begin
			@(posedge sys_clk);
			#1;
			n++;
		end while (core_reset !== v && n < 20);
		chk("core_reset", v, core_reset);
	endtask

	task automatic issue(input rbc_pkg::rbc_op_e op);
		@(posedge sys_clk);
		cmd_op <= op;
		cmd_go <= 1'b1;
		@(posedge sys_clk);
		cmd_go <= 1'b0;
	endtask

	// Two instructions on consecutive cycles, the tight arm sequence
	task automatic issue_pair(input rbc_pkg::rbc_op_e op_a, input rbc_pkg::rbc_op_e op_b);
		@(posedge sys_clk);
		cmd_op <= op_a;
		cmd_go <= 1'b1;
		@(posedge sys_clk);
		cmd_op <= op_b;
		@(posedge sys_clk);
		cmd_go <= 1'b0;
	endtask

	// Make state that a reset must visibly clear
	task automatic dirty();
		bus(1'b1, rbc_pkg::OFS_IRQ_CTRL_A, 32'h5);
		bus(1'b1, rbc_pkg::OFS_PULLUP_B, 32'hF);
		bus(1'b1, rbc_pkg::OFS_WAKEUP_A, 32'h1);
		bus(1'b1, rbc_pkg::OFS_FLAGS, 32'h1F);
	endtask

	// Held reset outputs, then release, restart and cleared state
	task automatic rst_cycle(input logic warm);
		int n;
		chk("io_force_hiz", 1, io_force_hiz);
		chk("io_latch_one", 1, io_latch_one);
		chk("pullup_force_off", 1, pullup_force_off);
		chk("pullup_en_b", 0, pullup_en_b);
		chk("pullup_en_c", 0, pullup_en_c);
		@(posedge sys_clk);
		sys_rst   <= 1'b0;
		ext_rst_n <= 1'b1;
		por_det   <= 1'b0;
		wdt_expire <= 1'b0;
		vdrop_det <= 1'b0;
		wake_req  <= 2'b00;
		// A warm restart drops core_reset an edge early, so look from here on
		#1;
		n = 0;
		while (fetch_zero !== 1'b1 && n < 20) begin
			@(posedge sys_clk);
			#1;
			n++;
		end
		chk("core_reset", 0, core_reset);
		chk("fetch_zero", 1, fetch_zero);
		chk("warm_flag", warm, warm_flag);
		chk("osc_stop", 0, osc_stop);
		if (!warm)
			chk("regs", RST_REGS, regs);
	endtask

	// Sources: 0 pin low, 1 power-on, 2 watchdog, 3 voltage drop
	task automatic cold_src(input int k);
		@(posedge sys_clk);
		case (k)
			0: ext_rst_n <= 1'b0;
			1: por_det <= 1'b1;
			2: wdt_expire <= 1'b1;
			default: vdrop_det <= 1'b1;
		endcase
		wait_rst(1);
		rst_cycle(1'b0);
	endtask

	// ****************************************************************
	// Tests
	// ****************************************************************
	initial begin
		sys_rst = 1'b1;
		avs_address = '0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = '0;
		ext_rst_n = 1'b1;
		por_det = 1'b0;
		vdrop_det = 1'b0;
		wdt_expire = 1'b0;
		wake_req = 2'b00;
		cmd_go = 1'b0;
		cmd_op = rbc_pkg::OP_OTHER;
		err_total = 0;
		n_checks = 0;
		idle(3);
		rst_cycle(1'b0);
		rd_chk("flags", rbc_pkg::OFS_FLAGS, 32'h20);
		for (int i = 0; i < 9; i++)
			bus(1'b1, 6'(4 * i), 32'(i + 7));
		for (int i = 0; i < 9; i++)
			rd_chk("control nibble", 6'(4 * i), 32'(i + 7));
		rd_chk("unmapped", 6'h2C, 32'h0);
		chk("pullup_en_b", 4'hD, pullup_en_b);
		chk("pullup_en_c", 4'hE, pullup_en_c);
		for (int k = 0; k < 4; k++) begin
			dirty();
			cold_src(k);
		end
		// Power-down without a directly preceding arm is ignored
		dirty();
		issue(rbc_pkg::OP_PD_KEEP);
		idle(4);
		chk("osc_stop", 0, osc_stop);
		issue(rbc_pkg::OP_ARM);
		issue(rbc_pkg::OP_OTHER);
		issue(rbc_pkg::OP_PD_FULL);
		idle(4);
		chk("osc_stop", 0, osc_stop);
		issue(rbc_pkg::OP_SKIP_WARM);
		idle(4);
		chk("skip cold", 0, skip_seen);
		// Keep-detector back-up, left by a voltage drop
		issue_pair(rbc_pkg::OP_ARM, rbc_pkg::OP_PD_KEEP);
		idle(4);
		chk("osc_stop", 1, osc_stop);
		chk("periph_halt", 0, periph_halt);
		chk("vdrop_enable", 1, vdrop_enable);
		cold_src(3);
		// Full back-up, detector ignored, left only by a qualified wakeup
		dirty();
		bus(1'b1, rbc_pkg::OFS_TIMER_CTRL_C, 32'h9);
		issue(rbc_pkg::OP_ARM);
		issue(rbc_pkg::OP_PD_FULL);
		idle(4);
		chk("osc_stop", 1, osc_stop);
		chk("periph_halt", 1, periph_halt);
		chk("vdrop_enable", 0, vdrop_enable);
		rd_chk("status", rbc_pkg::OFS_STATUS, 32'h4);
		@(posedge sys_clk);
		vdrop_det <= 1'b1;
		idle(6);
		chk("core_reset", 0, core_reset);
		@(posedge sys_clk);
		vdrop_det <= 1'b0;
		wake_req  <= 2'b10;
		idle(6);
		chk("osc_stop", 1, osc_stop);
		@(posedge sys_clk);
		wake_req <= 2'b01;
		wait_rst(1);
		rst_cycle(1'b1);
		rd_chk("timer_ctrl_c", rbc_pkg::OFS_TIMER_CTRL_C, 32'h9);
		rd_chk("flags", rbc_pkg::OFS_FLAGS, 32'h20);
		issue(rbc_pkg::OP_SKIP_WARM);
		idle(4);
		chk("skip warm", 1, skip_seen);
		cold_src(0);
		give_verdict();
	end

	// Watchdog: the tests need well under 30 us
	initial begin
		#100000;
		err_total++;
		$display("[FAIL] watchdog expired before the tests ended");
		give_verdict();
	end
endmodule
